/* File: bench/pah_checker.sv */
/* Port assertions for pah_core.
   Bound from the bench top; sees core ports only. */
`timescale 1ns/10ps
`include "pah_defines.vh"
module pah_checker (
  input wire        clock,
  input wire        rst_n,
  input wire        wr_req,
  input wire [2:0]  wr_idx,
  input wire        power_cycle,
  input wire        rst_cmd_req,
  input wire        rst_cmd_mode,
  input wire        servo_on_req,
  input wire        wr_ack_r,
  input wire        wr_rej_r,
  input wire        busy_r,
  input wire        cmd_done_r,
  input wire        cmd_err_r,
  input wire [15:0] cmd_err_code_r,
  input wire        position_init_error_alarm_r,
  input wire [31:0] deviation_r,
  input wire        latch_done_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  reg  [6:0] busy_cnt_r;
  wire       wr_clean;
  assign wr_clean = wr_req && !power_cycle && !rst_cmd_req;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      busy_cnt_r <= 7'h00;
    else
      busy_cnt_r <= busy_r ? busy_cnt_r + 7'h01 : 7'h00;
  end
  sequence s_enable;
    rst_cmd_req && rst_cmd_mode && !busy_r;
  endsequence
  sequence s_finish;
    $fell(busy_r);
  endsequence
  a_busy_length: assert property (s_finish |-> busy_cnt_r == 7'h42)
    else $error("busy length wrong");
  a_done_at_fall: assert property (s_finish |-> cmd_done_r)
    else $error("done missing at busy fall");
  a_enable_answer: assert property (s_enable |=> busy_r ||
    (cmd_err_r && cmd_err_code_r == `PAH_ERR_SERVO_ON))
    else $error("enable command answer wrong");
  a_busy_refuse: assert property (rst_cmd_req && busy_r |=>
    cmd_err_r && cmd_err_code_r == `PAH_ERR_BUSY)
    else $error("command during busy not refused");
  a_soft_done: assert property (rst_cmd_req && !rst_cmd_mode && !busy_r
    |=> cmd_done_r && !busy_r)
    else $error("soft reset answer wrong");
  // Five cycles cover the pin synchroniser latency
  a_alarm_set: assert property ((busy_r && servo_on_req)[*5]
    |-> ##[0:4] position_init_error_alarm_r)
    else $error("alarm not raised");
  a_alarm_cause: assert property ($rose(position_init_error_alarm_r)
    |-> $past(busy_r))
    else $error("alarm without busy");
  a_ro_reject: assert property (wr_clean && wr_idx == `PAH_IDX_READONLY
    |=> wr_rej_r && !wr_ack_r)
    else $error("read-only write not refused");
  a_done_reinit: assert property (s_finish |->
    deviation_r == 32'h0 && !latch_done_r)
    else $error("position or latch not reinitialised");
endmodule // pah_checker

/* File: bench/pah_core_tb.sv */
/* Self-checking bench for pah_core with host model and checker.
   Assumes core, header and bench files compile together. */
`timescale 1ns/10ps
`include "pah_defines.vh"
module pah_core_tb;
  logic        clock;
  logic        rst_n;
  logic [2:0]  rd_idx;
  wire         wr_req, nv_write_req, power_cycle, rst_cmd_req, rst_cmd_mode;
  wire         servo_on_req, alarm_clr, home_done, latch_event;
  wire [2:0]   wr_idx;
  wire [31:0]  wr_data, enc_value, fb_delta, cmd_delta;
  wire         wr_ack_r, wr_rej_r, busy_r, cmd_done_r, cmd_err_r;
  wire         position_init_error_alarm_r, homing_done_r, latch_done_r;
  wire [15:0]  cmd_err_code_r;
  wire [31:0]  rd_data_r, actual_pos_r, command_pos_r, deviation_r;
  int          error_cnt;
  int          n_compared;
  pah_host host (
    .clock        (clock),
    .wr_req       (wr_req),
    .wr_idx       (wr_idx),
    .wr_data      (wr_data),
    .nv_write_req (nv_write_req),
    .power_cycle  (power_cycle),
    .rst_cmd_req  (rst_cmd_req),
    .rst_cmd_mode (rst_cmd_mode),
    .servo_on_req (servo_on_req),
    .alarm_clr    (alarm_clr),
    .enc_value    (enc_value),
    .fb_delta     (fb_delta),
    .cmd_delta    (cmd_delta),
    .home_done    (home_done),
    .latch_event  (latch_event)
  );
  pah_core DUT (
    .clock                       (clock),
    .rst_n                       (rst_n),
    .wr_req                      (wr_req),
    .wr_idx                      (wr_idx),
    .wr_data                     (wr_data),
    .rd_idx                      (rd_idx),
    .nv_write_req                (nv_write_req),
    .power_cycle                 (power_cycle),
    .rst_cmd_req                 (rst_cmd_req),
    .rst_cmd_mode                (rst_cmd_mode),
    .servo_on_req                (servo_on_req),
    .alarm_clr                   (alarm_clr),
    .enc_value                   (enc_value),
    .fb_delta                    (fb_delta),
    .cmd_delta                   (cmd_delta),
    .home_done                   (home_done),
    .latch_event                 (latch_event),
    .wr_ack_r                    (wr_ack_r),
    .wr_rej_r                    (wr_rej_r),
    .rd_data_r                   (rd_data_r),
    .busy_r                      (busy_r),
    .cmd_done_r                  (cmd_done_r),
    .cmd_err_r                   (cmd_err_r),
    .cmd_err_code_r              (cmd_err_code_r),
    .position_init_error_alarm_r (position_init_error_alarm_r),
    .actual_pos_r                (actual_pos_r),
    .command_pos_r               (command_pos_r),
    .deviation_r                 (deviation_r),
    .homing_done_r               (homing_done_r),
    .latch_done_r                (latch_done_r)
  );
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string what, input [31:0] exp, input [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rd(input [2:0] i, input [31:0] exp);
    @(posedge clock);
    #1 rd_idx = i;
    @(posedge clock);
    #1 chk("slot", exp, rd_data_r);
  endtask
  task automatic wait_done(output int n);
    n = 0;
    while (cmd_done_r !== 1'b1 && n < 200) begin
      @(posedge clock);
      #1 n++;
    end
  endtask
  task automatic run(input [31:0] pos, input home);
    int n;
    host.move(32'h3);
    host.ev(5'h0c);
    host.cmd(1'b1);
    chk("busy", 1, busy_r);
    wait_done(n);
    chk("busy span", 66, n);
    chk("actual", pos, actual_pos_r);
    chk("command", pos, command_pos_r);
    chk("deviation", 0, deviation_r);
    chk("homing", home, homing_done_r);
    chk("latch", 0, latch_done_r);
    host.ev(5'h04);
    chk("rehomed", 1, homing_done_r);
  endtask
  task automatic t_ab;
    host.wr(`PAH_IDX_GENERAL_A, 32'h1234);
    chk("ack", 1, wr_ack_r);
    chk_rd(`PAH_IDX_GENERAL_A, 32'h1234);
    host.wr(`PAH_IDX_GENERAL_B, 32'h5678);
    chk_rd(`PAH_IDX_GENERAL_B, 32'h5678);
    host.wr(`PAH_IDX_READONLY, 32'h55);
    chk("reject", 1, wr_rej_r);
    chk("no ack", 0, wr_ack_r);
    chk_rd(`PAH_IDX_READONLY, `PAH_DEF_READONLY);
  endtask
  task automatic t_r;
    host.wr(`PAH_IDX_GENERAL_R, 32'h5);
    chk_rd(`PAH_IDX_GENERAL_R, 0);
    host.ev(5'h01);
    host.cmd(1'b0);
    chk("soft done", 1, cmd_done_r);
    chk_rd(`PAH_IDX_GENERAL_R, 32'h5);
    host.wr(`PAH_IDX_GENERAL_A, 32'h9);
    host.cmd(1'b0);
    chk_rd(`PAH_IDX_GENERAL_A, 32'h1234);
    host.wr(`PAH_IDX_GENERAL_R, 32'h6);
    host.ev(5'h02);
    chk_rd(`PAH_IDX_GENERAL_R, 32'h5);
  endtask
  // Mode and offset switch over only after the run that applies them
  task automatic t_c;
    host.wr(`PAH_IDX_GEAR_NUM, 32'h4);
    host.wr(`PAH_IDX_GEAR_DEN, 32'h2);
    host.wr(`PAH_IDX_HOME_OFS, 32'h7);
    chk_rd(`PAH_IDX_GEAR_NUM, `PAH_DEF_GEAR_NUM);
    run(32'h32, 1'b1);
    chk_rd(`PAH_IDX_GEAR_NUM, 32'h4);
    host.wr(`PAH_IDX_ABS_MODE, 32'h0);
    host.enc(32'h70);
    run(32'h3f, 1'b1);
    run(32'h0, 1'b0);
  endtask
  task automatic t_err;
    host.servo(1'b1);
    repeat (6) @(posedge clock);
    host.cmd(1'b1);
    chk("servo err", 1, cmd_err_r);
    chk("err code", `PAH_ERR_SERVO_ON, cmd_err_code_r);
    chk("busy", 0, busy_r);
    host.servo(1'b0);
    repeat (6) @(posedge clock);
  endtask
  task automatic t_alarm;
    int n;
    host.cmd(1'b1);
    host.cmd(1'b0);
    chk("busy code", `PAH_ERR_BUSY, cmd_err_code_r);
    host.servo(1'b1);
    wait_done(n);
    chk("alarm span", 63, n);
    chk("alarm", 1, position_init_error_alarm_r);
    host.servo(1'b0);
    repeat (6) @(posedge clock);
    host.ev(5'h10);
    chk("alarm clear", 0, position_init_error_alarm_r);
  endtask
  task automatic results;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst_n = 1'b0;
    rd_idx = 3'h0;
    repeat (10) @(posedge clock);
    #1 rst_n = 1'b1;
    t_ab;
    t_r;
    t_c;
    t_err;
    t_alarm;
    results;
  end
  initial begin
    #100000;
    error_cnt++;
    results;
  end
endmodule // pah_core_tb
bind pah_core pah_checker u_chk (
  .clock                       (clock),
  .rst_n                       (rst_n),
  .wr_req                      (wr_req),
  .wr_idx                      (wr_idx),
  .power_cycle                 (power_cycle),
  .rst_cmd_req                 (rst_cmd_req),
  .rst_cmd_mode                (rst_cmd_mode),
  .servo_on_req                (servo_on_req),
  .wr_ack_r                    (wr_ack_r),
  .wr_rej_r                    (wr_rej_r),
  .busy_r                      (busy_r),
  .cmd_done_r                  (cmd_done_r),
  .cmd_err_r                   (cmd_err_r),
  .cmd_err_code_r              (cmd_err_code_r),
  .position_init_error_alarm_r (position_init_error_alarm_r),
  .deviation_r                 (deviation_r),
  .latch_done_r                (latch_done_r)
);

/* File: bench/pah_host.sv */
/* Host controller model driving the pah_core inputs.
   Assumes one clock; changes land 1 ns after the rising edge. */
`timescale 1ns/10ps
module pah_host (
  input  wire         clock,
  output logic        wr_req,
  output logic [2:0]  wr_idx,
  output logic [31:0] wr_data,
  output logic        nv_write_req,
  output logic        power_cycle,
  output logic        rst_cmd_req,
  output logic        rst_cmd_mode,
  output logic        servo_on_req,
  output logic        alarm_clr,
  output logic [31:0] enc_value,
  output logic [31:0] fb_delta,
  output logic [31:0] cmd_delta,
  output logic        home_done,
  output logic        latch_event
);
  initial begin
    {wr_req, wr_idx, wr_data} = 36'h0;
    {nv_write_req, power_cycle, rst_cmd_req, rst_cmd_mode} = 4'h0;
    {servo_on_req, alarm_clr, home_done, latch_event} = 4'h0;
    enc_value = 32'h64;
    {fb_delta, cmd_delta} = 64'h0;
  end
  task automatic step;
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input [2:0] i, input [31:0] d);
    step();
    {wr_req, wr_idx, wr_data} = {1'b1, i, d};
    step();
    wr_req = 1'b0;
    wr_data = ~d; // Stale data must not look valid
  endtask
  // Mask order: clear, latch, home, power, nv
  task automatic ev(input [4:0] m);
    step();
    {alarm_clr, latch_event, home_done, power_cycle, nv_write_req} = m;
    step();
    {alarm_clr, latch_event, home_done, power_cycle, nv_write_req} = 5'h00;
  endtask
  task automatic cmd(input mode);
    step();
    {rst_cmd_req, rst_cmd_mode} = {1'b1, mode};
    step();
    rst_cmd_req = 1'b0;
  endtask
  // Servo raised around a command only when a test asks
  task automatic servo(input v);
    step();
    servo_on_req = v;
  endtask
  task automatic enc(input [31:0] v);
    step();
    enc_value = v;
  endtask
  // Motion stops before any parameter write follows
  task automatic move(input [31:0] d);
    step();
    fb_delta = d;
    cmd_delta = d + 32'h1;
    repeat (4) step();
    {fb_delta, cmd_delta} = 64'h0;
  endtask
endmodule // pah_host

/* File: core/pah_core.v */
/*
  Parameter store with attribute-dependent apply timing, nonvolatile image,
  and the reset command sequencer (soft reset and class C enable mode).
  Assumes commands come from same-clock logic; servo_on_req is a pin-level
  input and is synchronised here.
*/
`timescale 1ns/10ps
`include "pah_defines.vh"
module pah_core (
  clock,
  rst_n,
  wr_req,
  wr_idx,
  wr_data,
  rd_idx,
  nv_write_req,
  power_cycle,
  rst_cmd_req,
  rst_cmd_mode,
  servo_on_req,
  alarm_clr,
  enc_value,
  fb_delta,
  cmd_delta,
  home_done,
  latch_event,
  wr_ack_r,
  wr_rej_r,
  rd_data_r,
  busy_r,
  cmd_done_r,
  cmd_err_r,
  cmd_err_code_r,
  position_init_error_alarm_r,
  actual_pos_r,
  command_pos_r,
  deviation_r,
  homing_done_r,
  latch_done_r
);
  input  wire                     clock;
  input  wire                     rst_n;
  input  wire                     wr_req;
  input  wire [`PAH_IDX_W-1:0]    wr_idx;
  input  wire [`PAH_DATA_W-1:0]   wr_data;
  input  wire [`PAH_IDX_W-1:0]    rd_idx;
  input  wire                     nv_write_req;
  input  wire                     power_cycle;
  input  wire                     rst_cmd_req;
  input  wire                     rst_cmd_mode;
  input  wire                     servo_on_req;
  input  wire                     alarm_clr;
  input  wire [`PAH_DATA_W-1:0]   enc_value;
  input  wire [`PAH_DATA_W-1:0]   fb_delta;
  input  wire [`PAH_DATA_W-1:0]   cmd_delta;
  input  wire                     home_done;
  input  wire                     latch_event;
  output reg                      wr_ack_r;
  output reg                      wr_rej_r;
  output reg  [`PAH_DATA_W-1:0]   rd_data_r;
  output reg                      busy_r;
  output reg                      cmd_done_r;
  output reg                      cmd_err_r;
  output reg  [15:0]              cmd_err_code_r;
  output reg                      position_init_error_alarm_r;
  output reg  [`PAH_DATA_W-1:0]   actual_pos_r;
  output reg  [`PAH_DATA_W-1:0]   command_pos_r;
  output reg  [`PAH_DATA_W-1:0]   deviation_r;
  output reg                      homing_done_r;
  output reg                      latch_done_r;

  function [2:0] pah_attr;
    input [`PAH_IDX_W-1:0] idx;
    begin
      case (idx)
        `PAH_IDX_GENERAL_A: pah_attr = `PAH_ATTR_A;
        `PAH_IDX_GENERAL_B: pah_attr = `PAH_ATTR_B;
        `PAH_IDX_GEAR_NUM:  pah_attr = `PAH_ATTR_C;
        `PAH_IDX_GEAR_DEN:  pah_attr = `PAH_ATTR_C;
        `PAH_IDX_ABS_MODE:  pah_attr = `PAH_ATTR_C;
        `PAH_IDX_HOME_OFS:  pah_attr = `PAH_ATTR_C;
        `PAH_IDX_GENERAL_R: pah_attr = `PAH_ATTR_R;
        default:            pah_attr = `PAH_ATTR_RO;
      endcase
    end
  endfunction

  function [`PAH_DATA_W-1:0] pah_def;
    input [`PAH_IDX_W-1:0] idx;
    begin
      case (idx)
        `PAH_IDX_GENERAL_A: pah_def = `PAH_DEF_GENERAL_A;
        `PAH_IDX_GENERAL_B: pah_def = `PAH_DEF_GENERAL_B;
        `PAH_IDX_GEAR_NUM:  pah_def = `PAH_DEF_GEAR_NUM;
        `PAH_IDX_GEAR_DEN:  pah_def = `PAH_DEF_GEAR_DEN;
        `PAH_IDX_ABS_MODE:  pah_def = `PAH_DEF_ABS_MODE;
        `PAH_IDX_HOME_OFS:  pah_def = `PAH_DEF_HOME_OFS;
        `PAH_IDX_GENERAL_R: pah_def = `PAH_DEF_GENERAL_R;
        default:            pah_def = `PAH_DEF_READONLY;
      endcase
    end
  endfunction

  // Staged value, live value and nonvolatile image per slot
  reg  [`PAH_DATA_W-1:0]  stg_r [0:`PAH_NPARAM-1];
  reg  [`PAH_DATA_W-1:0]  act_r [0:`PAH_NPARAM-1];
  reg  [`PAH_DATA_W-1:0]  nv_r  [0:`PAH_NPARAM-1];

  reg  [2:0]              state_r;
  reg  [2:0]              state_nxt;
  reg  [`PAH_CNT_W-1:0]   cnt_r;
  reg  [63:0]             dvd_r;
  reg  [32:0]             rem_r;
  reg  [`PAH_DATA_W-1:0]  num_r;
  reg  [32:0]             rem_sh;
  reg  [32:0]             rem_sub;
  wire                    servo_on;
  wire [2:0]              wr_attr;
  wire                    wr_ok;
  wire                    wr_live;
  wire                    cmd_idle;
  wire                    soft_go;
  wire                    cen_go;
  wire                    cen_refuse;
  wire                    reload;
  wire                    c_apply;
  wire                    abs_mode;
  wire [`PAH_DATA_W-1:0]  init_pos;

  pah_sync u_servo_sync (
    .clock (clock),
    .rst_n (rst_n),
    .din   (servo_on_req),
    .dout  (servo_on)
  );

  assign wr_attr    = pah_attr(wr_idx);
  assign wr_ok      = wr_req && (wr_attr != `PAH_ATTR_RO);
  assign wr_live    = (wr_attr == `PAH_ATTR_A) || (wr_attr == `PAH_ATTR_B);
  assign cmd_idle   = (state_r == `PAH_ST_IDLE);
  assign soft_go    = rst_cmd_req && cmd_idle && (rst_cmd_mode == `PAH_MODE_SOFT);
  // Enable mode is refused while the servo is on
  assign cen_refuse = rst_cmd_req && cmd_idle && (rst_cmd_mode == `PAH_MODE_CLASS_C)
                      && servo_on;
  assign cen_go     = rst_cmd_req && cmd_idle && (rst_cmd_mode == `PAH_MODE_CLASS_C)
                      && !servo_on;
  // Reload from the nonvolatile image drops unsaved edits
  assign reload     = power_cycle || soft_go;
  assign c_apply    = (state_r == `PAH_ST_FIN);
  assign abs_mode   = act_r[`PAH_IDX_ABS_MODE][0];
  assign init_pos   = abs_mode ? (dvd_r[31:0] + act_r[`PAH_IDX_HOME_OFS]) :
                                 {`PAH_DATA_W{1'b0}};

  genvar g;
  generate
    for (g = 0; g < `PAH_NPARAM; g = g + 1) begin : g_slot
      localparam integer              slot_n = g;
      localparam [`PAH_IDX_W-1:0]     slot   = slot_n[`PAH_IDX_W-1:0];
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          stg_r[g] <= pah_def(slot);
          act_r[g] <= pah_def(slot);
          nv_r[g]  <= pah_def(slot);
        end else begin
          if (reload) begin
            stg_r[g] <= nv_r[g];
            act_r[g] <= nv_r[g];
          end else begin
            if (wr_ok && (wr_idx == slot)) begin
              stg_r[g] <= wr_data;
            end
            if (wr_ok && wr_live && (wr_idx == slot)) begin
              act_r[g] <= wr_data;
            end else if (c_apply && (pah_attr(slot) == `PAH_ATTR_C)) begin
              act_r[g] <= stg_r[g];
            end
          end
          if (nv_write_req) begin
            nv_r[g] <= stg_r[g];
          end
        end
      end
    end
  endgenerate

  always @* begin
    state_nxt = state_r;
    case (state_r)
      `PAH_ST_IDLE: begin
        if (cen_go) begin
          state_nxt = `PAH_ST_DIV;
        end
      end
      `PAH_ST_DIV: begin
        if (cnt_r == `PAH_DIV_STEPS) begin
          state_nxt = `PAH_ST_FIN;
        end
      end
      `PAH_ST_FIN: begin
        state_nxt = `PAH_ST_IDLE;
      end
      default: begin
        state_nxt = `PAH_ST_IDLE;
      end
    endcase
  end

  // One restoring step of encoder*den / num
  always @* begin
    rem_sh  = {rem_r[31:0], dvd_r[63]};
    rem_sub = rem_sh - {1'b0, num_r};
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= `PAH_ST_IDLE;
      cnt_r   <= {`PAH_CNT_W{1'b0}};
      dvd_r   <= 64'h0000_0000_0000_0000;
      rem_r   <= 33'h0_0000_0000;
      num_r   <= {`PAH_DATA_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      if (cen_go) begin
        // Staged gear values, since they take effect with this command
        cnt_r <= {`PAH_CNT_W{1'b0}};
        dvd_r <= enc_value * stg_r[`PAH_IDX_GEAR_DEN];
        rem_r <= 33'h0_0000_0000;
        num_r <= stg_r[`PAH_IDX_GEAR_NUM];
      end else if ((state_r == `PAH_ST_DIV) && (cnt_r != `PAH_DIV_STEPS)) begin
        cnt_r <= cnt_r + 7'h01;
        if ((num_r != {`PAH_DATA_W{1'b0}}) && !rem_sub[32]) begin
          rem_r <= rem_sub;
          dvd_r <= {dvd_r[62:0], 1'b1};
        end else begin
          rem_r <= rem_sh;
          dvd_r <= {dvd_r[62:0], 1'b0};
        end
      end
    end
  end

  // Command status, busy flag and alarm
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_r                      <= 1'b0;
      cmd_done_r                  <= 1'b0;
      cmd_err_r                   <= 1'b0;
      cmd_err_code_r              <= `PAH_ERR_NONE;
      position_init_error_alarm_r <= 1'b0;
      wr_ack_r                    <= 1'b0;
      wr_rej_r                    <= 1'b0;
      rd_data_r                   <= {`PAH_DATA_W{1'b0}};
    end else begin
      busy_r     <= (state_nxt != `PAH_ST_IDLE);
      cmd_done_r <= c_apply || soft_go;
      cmd_err_r  <= cen_refuse || (rst_cmd_req && !cmd_idle);
      if (cen_refuse) begin
        cmd_err_code_r <= `PAH_ERR_SERVO_ON;
      end else if (rst_cmd_req && !cmd_idle) begin
        cmd_err_code_r <= `PAH_ERR_BUSY;
      end else if (rst_cmd_req) begin
        cmd_err_code_r <= `PAH_ERR_NONE;
      end
      // Set wins over a clear in the same cycle
      if (busy_r && servo_on) begin
        position_init_error_alarm_r <= 1'b1;
      end else if (alarm_clr) begin
        position_init_error_alarm_r <= 1'b0;
      end
      wr_ack_r  <= wr_ok;
      wr_rej_r  <= wr_req && !wr_ok;
      rd_data_r <= act_r[rd_idx];
    end
  end

  // Position, homing and latch; frozen while the command runs
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      actual_pos_r  <= {`PAH_DATA_W{1'b0}};
      command_pos_r <= {`PAH_DATA_W{1'b0}};
      deviation_r   <= {`PAH_DATA_W{1'b0}};
      homing_done_r <= 1'b0;
      latch_done_r  <= 1'b0;
    end else if (c_apply) begin
      actual_pos_r  <= init_pos;
      command_pos_r <= init_pos;
      deviation_r   <= {`PAH_DATA_W{1'b0}};
      homing_done_r <= abs_mode;
      latch_done_r  <= 1'b0;
    end else if (cmd_idle && !cen_go) begin
      actual_pos_r  <= actual_pos_r + fb_delta;
      command_pos_r <= command_pos_r + cmd_delta;
      deviation_r   <= deviation_r + cmd_delta - fb_delta;
      if (home_done) begin
        homing_done_r <= 1'b1;
      end
      if (latch_event) begin
        latch_done_r <= 1'b1;
      end
    end
  end
endmodule // pah_core

/* File: core/pah_defines.vh */
/*
  Constants of the parameter apply and reset handler: parameter slots,
  attribute classes, reset values, command codes and state codes.
  Assumes inclusion by bare name from the core module and the bench files.
*/
// How it works
// - Class C applies on enable reset or R-event
// - Class R applies on power cycle, soft reset
// - Read-only parameter writes rejected, value kept
// - Unsaved changes lost on power off, soft reset
// - Enable mode needs no prior nonvolatile write
// - Enable reset with servo on errors 0045h
// - Servo on during enable reset raises alarm
// - Position reinitialised: zero or encoder/gear plus offset
// - Homing cleared incremental, complete absolute afterwards
// - Latch complete cleared after reset, any mode
// - Busy 0, 1 while running, 0; status held (cmd_done_r and cmd_err_r pulse for one cycle)
// - Class A and B changes apply immediately
`ifndef PAH_DEFINES_VH
`define PAH_DEFINES_VH

`define PAH_NPARAM        8
`define PAH_IDX_W         3
`define PAH_DATA_W        32

// Attribute classes
`define PAH_ATTR_A        3'h0
`define PAH_ATTR_B        3'h1
`define PAH_ATTR_C        3'h2
`define PAH_ATTR_R        3'h3
`define PAH_ATTR_RO       3'h4

// Parameter slots
`define PAH_IDX_GENERAL_A 3'h0
`define PAH_IDX_GENERAL_B 3'h1
`define PAH_IDX_GEAR_NUM  3'h2
`define PAH_IDX_GEAR_DEN  3'h3
`define PAH_IDX_ABS_MODE  3'h4
`define PAH_IDX_HOME_OFS  3'h5
`define PAH_IDX_GENERAL_R 3'h6
`define PAH_IDX_READONLY  3'h7

// Reset values of the slots
`define PAH_DEF_GENERAL_A 32'h0000_0000
`define PAH_DEF_GENERAL_B 32'h0000_0000
`define PAH_DEF_GEAR_NUM  32'h0000_0001
`define PAH_DEF_GEAR_DEN  32'h0000_0001
`define PAH_DEF_ABS_MODE  32'h0000_0001
`define PAH_DEF_HOME_OFS  32'h0000_0000
`define PAH_DEF_GENERAL_R 32'h0000_0000
`define PAH_DEF_READONLY  32'h0000_0000

// Reset command modes
`define PAH_MODE_SOFT     1'b0
`define PAH_MODE_CLASS_C  1'b1

// Command error codes
`define PAH_ERR_SERVO_ON  16'h0045
`define PAH_ERR_BUSY      16'h0001
`define PAH_ERR_NONE      16'h0000

// Division steps for the absolute position
`define PAH_DIV_STEPS     7'h40
`define PAH_CNT_W         7

// One-hot sequencer states
`define PAH_ST_IDLE       3'h1
`define PAH_ST_DIV        3'h2
`define PAH_ST_FIN        3'h4

`endif

/* File: core/pah_sync.v */
/*
  Three-stage synchroniser with agreement filter for one level.
  Assumes an asynchronous level input and one clock domain.
*/
`timescale 1ns/10ps
module pah_sync (
  clock,
  rst_n,
  din,
  dout
);
  input  wire clock;
  input  wire rst_n;
  input  wire din;
  output reg  dout;

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // Output changes only once stages two and three agree
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule // pah_sync
